// file: core/aor_option_bank.sv
/*
  Per-axis option register bank with the pin and start logic it steers.
  Assumes i_axis_moving, i_motion_active, boot load and request inputs come
  from logic on i_clk; i_phys_dir_pin and i_gp_in are asynchronous pins.
*/
`timescale 1ns/1ns

// Functional notes
// - Only the write command, accepted while the axis is stopped, or a flash reload loads the option register.
// - Bit 23 turns on parameter auto-correction and bit 22 turns on pattern reduction.
// - Bits 21, 18 and 17 enable stop notification, automatic start and overscale when 1.
// - Bit 20 inverts the direction output and bit 19 the physical direction input, when 1.
// - Bit 16 gates axis start by general output three and bit 4 inverts that output when 1.
// - When 1, bits 15, 10, 8, 9 pick decel stop, net-fail stop, limit stop, physical compare.
// - Bit 14 picks external-signal sync when 1 and shared-data sync when 0.
// - Bit 13 reads acceleration as time when 1 and bit 12 treats distance as absolute when 1.
// - Bit 11 clears general outputs zero and one, and two unless bit 5 is 1, on network failure and bit 3 inverts them.
// - Bit 5 turns general output two into the motion-active signal.
// - Bits 2 to 1 set inputs two and three to normal, stop sensor, single step or continuous.
// - Bit 0 turns general input one into a stop-signal input.
// - The factory content is 0xC08500.
// - Reset loads the factory content; the saved flash value of this axis is loaded only when a boot load is requested.
module aor_option_bank
  import aor_pkg::*;
(
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic         i_ce,
  input  wire aor_bus_req_t i_bus,
  output logic [23:0]       o_rdata,
  input  wire logic         i_axis_moving,
  input  wire logic         i_motion_active,
  input  wire logic         i_boot_load,
  input  wire logic [23:0]  i_boot_data,
  input  wire logic         i_dir_raw,
  input  wire logic         i_phys_dir_pin,
  input  wire logic [3:1]   i_gp_in,
  input  wire logic [3:0]   i_gp_out_req,
  input  wire logic         i_net_fail_flag,
  input  wire logic         i_launch_req,
  output aor_opt_cfg_t      o_cfg,
  output logic              o_dir_pin,
  output logic              o_phys_dir,
  output logic [3:0]        o_gp_out,
  output logic              o_launch,
  output logic              o_net_stop,
  output logic              o_stop_signal,
  output logic              o_stop_sensor,
  output logic              o_manual_step,
  output logic              o_manual_cont,
  output logic [3:1]        o_gp_in_plain
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  aor_opt_cfg_t cfg_r;
  aor_opt_cfg_t cfg_nxt;
  logic [23:0]  assist_r;
  logic         taken_r;
  logic         refused_r;
  logic [3:0]   sync_a_r;
  logic [3:0]   sync_b_r;
  logic [23:0]  rdata_nxt;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic        assist_wr    = i_bus.wr && (i_bus.addr == AOR_OFS_ASSIST);
  wire logic        cmd_hit      = i_bus.wr && (i_bus.addr == AOR_OFS_CMD) &&
                                   (i_bus.wdata[7:0] == AOR_CMD_OPT_WRITE);
  wire logic        cmd_take     = cmd_hit && !i_axis_moving;
  wire logic        cmd_drop     = cmd_hit && i_axis_moving;
  wire logic [23:0] assist_clean = assist_r & AOR_RSVD_MASK;
  wire logic [23:0] boot_clean   = i_boot_data & AOR_RSVD_MASK;
  wire logic [23:0] stat_word    = {21'h000000, refused_r, taken_r, i_axis_moving};

  // Flash reload wins, then the write command; direct writes never reach it
  assign cfg_nxt = i_boot_load ? aor_opt_cfg_t'(boot_clean)   :
                   cmd_take    ? aor_opt_cfg_t'(assist_clean) :
                                 cfg_r;

  assign rdata_nxt = !i_bus.rd                     ? 24'h000000 :
                     (i_bus.addr == AOR_OFS_ASSIST) ? assist_r :
                     (i_bus.addr == AOR_OFS_CFG)   ? 24'(cfg_r) :
                     (i_bus.addr == AOR_OFS_STAT)  ? stat_word :
                                                     24'h000000;

  // ----------------------------------------------------------------
  // Pin logic
  // ----------------------------------------------------------------
  wire logic       phys_s   = sync_b_r[0];
  wire logic [3:1] gin_s    = sync_b_r[3:1];
  wire logic       net_clr  = cfg_r.out0_2_clear_en && i_net_fail_flag;
  wire logic [2:0] out012_l = net_clr ? 3'h0 : i_gp_out_req[2:0];
  wire logic       out2_l   = cfg_r.out2_func_sel ? i_motion_active : out012_l[2];
  wire logic [2:0] out012_p = {out2_l, out012_l[1:0]} ^ {3{cfg_r.out0_2_invert}};
  wire logic       out3_p   = i_gp_out_req[3] ^ cfg_r.out3_invert;
  wire logic       launch_n = i_launch_req &&
                              (!cfg_r.launch_gated_by_out3 || i_gp_out_req[3]);
  wire logic       is_stop  = cfg_r.in2_3_func_sel == AOR_IN23_STOP;
  wire logic       is_step  = cfg_r.in2_3_func_sel == AOR_IN23_STEP;
  wire logic       is_cont  = cfg_r.in2_3_func_sel == AOR_IN23_CONT;
  wire logic       is_norm  = cfg_r.in2_3_func_sel == AOR_IN23_NORMAL;
  wire logic [3:1] plain_n  = {{2{is_norm}} & gin_s[3:2], !cfg_r.in1_func_sel && gin_s[1]};

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_r     <= aor_opt_cfg_t'(AOR_CFG_DEFAULT);
      assist_r  <= AOR_ASSIST_DEFAULT;
      taken_r   <= 1'b0;
      refused_r <= 1'b0;
      o_rdata   <= 24'h000000;
    end else if (i_ce) begin
      cfg_r   <= cfg_nxt;
      o_rdata <= rdata_nxt;
      if (assist_wr) begin
        assist_r <= i_bus.wdata;
      end
      if (cmd_hit) begin
        taken_r   <= cmd_take;
        refused_r <= cmd_drop;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync_a_r <= 4'h0;
      sync_b_r <= 4'h0;
    end else if (i_ce) begin
      sync_a_r <= {i_gp_in, i_phys_dir_pin};
      sync_b_r <= sync_a_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cfg         <= aor_opt_cfg_t'(AOR_CFG_DEFAULT);
      o_dir_pin     <= 1'b0;
      o_phys_dir    <= 1'b0;
      o_gp_out      <= 4'h0;
      o_launch      <= 1'b0;
      o_net_stop    <= 1'b0;
      o_stop_signal <= 1'b0;
      o_stop_sensor <= 1'b0;
      o_manual_step <= 1'b0;
      o_manual_cont <= 1'b0;
      o_gp_in_plain <= 3'h0;
    end else if (i_ce) begin
      o_cfg         <= cfg_r;
      o_dir_pin     <= i_dir_raw ^ cfg_r.dir_out_invert;
      o_phys_dir    <= phys_s ^ cfg_r.phys_dir_in_invert;
      o_gp_out      <= {out3_p, out012_p};
      o_launch      <= launch_n;
      o_net_stop    <= cfg_r.net_loss_stop_en && i_net_fail_flag;
      o_stop_signal <= cfg_r.in1_func_sel && gin_s[1];
      o_stop_sensor <= is_stop && (gin_s[2] || gin_s[3]);
      o_manual_step <= is_step && (gin_s[2] || gin_s[3]);
      o_manual_cont <= is_cont && (gin_s[2] || gin_s[3]);
      o_gp_in_plain <= plain_n;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sequence seq_cmd_take;
    i_ce && cmd_take && !i_boot_load;
  endsequence

  sequence seq_cmd_moving;
    i_ce && cmd_hit && i_axis_moving && !i_boot_load;
  endsequence

  sequence seq_cfg_seen;
    i_ce [*2];
  endsequence

  a_cfg_copy_assist: assert property (
    seq_cmd_take |=> (24'(cfg_r) == $past(assist_clean)) && taken_r)
    else $error("option register did not take write-assist data");

  a_cfg_copy_out: assert property (
    seq_cmd_take ##1 seq_cfg_seen |-> 24'(o_cfg) == $past(assist_clean, 2))
    else $error("option output did not follow accepted write");

  a_direct_write_ignored: assert property (
    (i_ce && i_bus.wr && !cmd_take && !i_boot_load) |=> $stable(cfg_r))
    else $error("option register changed without write command");

  a_moving_write_held: assert property (
    seq_cmd_moving |=> $stable(cfg_r) && refused_r && !taken_r)
    else $error("write command while moving was not refused");

  a_boot_reload: assert property (
    (i_ce && i_boot_load) |=> 24'(cfg_r) == $past(boot_clean))
    else $error("flash reload not applied");

  a_reserved_zero: assert property (
    cfg_r.rsvd == 2'b00)
    else $error("reserved option bits not zero");

  a_dir_invert: assert property (
    i_ce |=> o_dir_pin == ($past(i_dir_raw) ^ $past(cfg_r.dir_out_invert)))
    else $error("direction output polarity wrong");

  a_phys_dir_sync: assert property (
    i_ce [*3] |=> o_phys_dir == ($past(i_phys_dir_pin, 3) ^ $past(cfg_r.phys_dir_in_invert)))
    else $error("physical direction input path wrong");

  a_launch_gated: assert property (
    (i_ce && cfg_r.launch_gated_by_out3 && !i_gp_out_req[3]) |=> !o_launch)
    else $error("start not held by output three");

  a_launch_free: assert property (
    (i_ce && !cfg_r.launch_gated_by_out3) |=> o_launch == $past(i_launch_req))
    else $error("start gated without option");

  a_out3_invert: assert property (
    i_ce |=> o_gp_out[3] == ($past(i_gp_out_req[3]) ^ $past(cfg_r.out3_invert)))
    else $error("output three polarity wrong");

  a_out2_motion: assert property (
    (i_ce && cfg_r.out2_func_sel && !net_clr) |=>
      o_gp_out[2] == ($past(i_motion_active) ^ $past(cfg_r.out0_2_invert)))
    else $error("output two not showing motion activity");

  a_net_clear: assert property (
    (i_ce && net_clr && !cfg_r.out2_func_sel) |=> o_gp_out[2:0] == {3{$past(cfg_r.out0_2_invert)}})
    else $error("outputs zero to two not cleared on network failure");

  a_net_stop: assert property (
    (i_ce && i_net_fail_flag) |=> o_net_stop == $past(cfg_r.net_loss_stop_en))
    else $error("network-failure stop not following enable");

  a_in1_stop: assert property (
    (i_ce && !cfg_r.in1_func_sel) |=> !o_stop_signal)
    else $error("stop signal raised with input one in normal role");

  a_in23_roles: assert property (
    i_ce |=> $onehot0({o_stop_sensor, o_manual_step, o_manual_cont}) &&
             (o_stop_sensor -> $past(cfg_r.in2_3_func_sel) == AOR_IN23_STOP))
    else $error("inputs two and three role mixed");

  a_read_cfg: assert property (
    (i_ce && i_bus.rd && i_bus.addr == AOR_OFS_CFG) |=> o_rdata == $past(24'(cfg_r)))
    else $error("option register read back wrong");

  // ----------------------------------------------------------------
  // Assertions on read port, clock enable, option output, command flags, network stop and input roles
  // ----------------------------------------------------------------
  a_read_idle_zero: assert property (
    (i_ce && !i_bus.rd) |=> o_rdata == 24'h000000)
    else $error("read data not zero outside a read");

  a_read_status: assert property (
    (i_ce && i_bus.rd && i_bus.addr == AOR_OFS_STAT) |=>
      o_rdata == {21'h000000, $past(refused_r), $past(taken_r), $past(i_axis_moving)})
    else $error("status read back wrong");

  a_read_assist: assert property (
    (i_ce && i_bus.rd && i_bus.addr == AOR_OFS_ASSIST) |=> o_rdata == $past(assist_r))
    else $error("write-assist register read back wrong");

  a_ce_freeze: assert property (
    !i_ce |=> $stable(cfg_r) && $stable(o_cfg) && $stable(o_rdata) && $stable(assist_r))
    else $error("state moved while clock enable low");

  a_cfg_out_follow: assert property (
    i_ce |=> o_cfg == $past(cfg_r))
    else $error("option output not one cycle behind register");

  a_cmd_flags: assert property (
    (i_ce && cmd_hit) |=>
      taken_r == !$past(i_axis_moving) && refused_r == $past(i_axis_moving))
    else $error("command flags do not match axis state");

  a_net_stop_idle: assert property (
    (i_ce && !i_net_fail_flag) |=> !o_net_stop)
    else $error("network-failure stop without failure");

  a_step_role: assert property (
    (i_ce && cfg_r.in2_3_func_sel != AOR_IN23_STEP) |=> !o_manual_step)
    else $error("single step raised outside its role");

  a_cont_role: assert property (
    (i_ce && cfg_r.in2_3_func_sel != AOR_IN23_CONT) |=> !o_manual_cont)
    else $error("continuous step raised outside its role");

  a_plain_in23: assert property (
    (i_ce && cfg_r.in2_3_func_sel != AOR_IN23_NORMAL) |=> o_gp_in_plain[3:2] == 2'b00)
    else $error("inputs two and three passed while in a special role");

  a_plain_in1: assert property (
    (i_ce && cfg_r.in1_func_sel) |=> !o_gp_in_plain[1])
    else $error("input one passed while used as stop signal");

endmodule // aor_option_bank

// file: core/aor_pkg.sv
/*
  Shared constants and types of the per-axis option register bank.
  Assumes one bank per axis, a plain register port and a same-clock motion core.
*/
package aor_pkg;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int          AOR_ADDR_W     = 4;
  localparam int          AOR_DATA_W     = 24;
  localparam logic [3:0]  AOR_OFS_ASSIST = 4'h0;
  localparam logic [3:0]  AOR_OFS_CFG    = 4'h1;
  localparam logic [3:0]  AOR_OFS_CMD    = 4'h2;
  localparam logic [3:0]  AOR_OFS_STAT   = 4'h3;

  // ----------------------------------------------------------------
  // Commands, values after reset, field masks
  // ----------------------------------------------------------------
  localparam logic [7:0]  AOR_CMD_OPT_WRITE  = 8'h20;
  localparam logic [23:0] AOR_CFG_DEFAULT    = 24'hc08500;
  localparam logic [23:0] AOR_ASSIST_DEFAULT = 24'h000000;
  localparam logic [23:0] AOR_RSVD_MASK      = 24'hffff3f;
  localparam int          AOR_STAT_MOVING    = 0;
  localparam int          AOR_STAT_TAKEN     = 1;
  localparam int          AOR_STAT_REFUSED   = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    AOR_IN23_NORMAL,
    AOR_IN23_STOP,
    AOR_IN23_STEP,
    AOR_IN23_CONT
  } aor_in23_mode_t;

  typedef struct packed {
    logic           param_autofix_en;
    logic           pattern_shrink_en;
    logic           halt_notice_en;
    logic           dir_out_invert;
    logic           phys_dir_in_invert;
    logic           auto_launch_en;
    logic           overscale_en;
    logic           launch_gated_by_out3;
    logic           stop_style_sel;
    logic           sync_source_sel;
    logic           accel_format_sel;
    logic           distance_mode_sel;
    logic           out0_2_clear_en;
    logic           net_loss_stop_en;
    logic           limit_compare_src;
    logic           limit_stop_en;
    logic [1:0]     rsvd;
    logic           out2_func_sel;
    logic           out3_invert;
    logic           out0_2_invert;
    aor_in23_mode_t in2_3_func_sel;
    logic           in1_func_sel;
  } aor_opt_cfg_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [23:0] wdata;
    logic        wr;
    logic        rd;
  } aor_bus_req_t;

endpackage

// file: test/aor_option_bank_tb.sv
/*
  Self-checking testbench of the per-axis option register bank.
  Assumes the bank answers reads one cycle later and never stalls the bus.
*/
`timescale 1ns/1ns

module aor_option_bank_tb import aor_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic         i_clk, i_rst_b, i_ce, i_axis_moving, i_motion_active;
  logic         i_boot_load, i_dir_raw, i_phys_dir_pin;
  logic         i_net_fail_flag, i_launch_req;
  aor_bus_req_t i_bus;
  logic [23:0]  i_boot_data, o_rdata, rd_val;
  logic [3:1]   i_gp_in, o_gp_in_plain;
  logic [3:0]   i_gp_out_req, o_gp_out;
  aor_opt_cfg_t o_cfg;
  logic         o_dir_pin, o_phys_dir, o_launch, o_net_stop;
  logic         o_stop_signal, o_stop_sensor, o_manual_step, o_manual_cont;
  int           n_mismatch, n_compared;
  int           bits [11] = '{23, 22, 21, 18, 17, 15, 14, 13, 12, 9, 8};

  aor_option_bank u_aor_option_bank (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_bus(i_bus), .o_rdata(o_rdata),
    .i_axis_moving(i_axis_moving), .i_motion_active(i_motion_active),
    .i_boot_load(i_boot_load), .i_boot_data(i_boot_data), .i_dir_raw(i_dir_raw),
    .i_phys_dir_pin(i_phys_dir_pin), .i_gp_in(i_gp_in), .i_gp_out_req(i_gp_out_req),
    .i_net_fail_flag(i_net_fail_flag), .i_launch_req(i_launch_req), .o_cfg(o_cfg),
    .o_dir_pin(o_dir_pin), .o_phys_dir(o_phys_dir), .o_gp_out(o_gp_out),
    .o_launch(o_launch), .o_net_stop(o_net_stop), .o_stop_signal(o_stop_signal),
    .o_stop_sensor(o_stop_sensor), .o_manual_step(o_manual_step),
    .o_manual_cont(o_manual_cont), .o_gp_in_plain(o_gp_in_plain)
  );

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus_op(input logic [3:0] a, input logic [23:0] d, input logic w);
    @(posedge i_clk);
    i_bus <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge i_clk);
    i_bus <= '0;
    #1 rd_val = o_rdata;
  endtask

  task automatic read_chk(input logic [3:0] a, input logic [23:0] exp);
    bus_op(a, 24'h000000, 1'b0);
    check(rd_val, exp);
  endtask

  task automatic set_cfg(input logic [23:0] d);
    bus_op(AOR_OFS_ASSIST, d, 1'b1);
    bus_op(AOR_OFS_CMD, {16'h0000, AOR_CMD_OPT_WRITE}, 1'b1);
    repeat (5) @(posedge i_clk);
    #1;
  endtask

  task automatic tally_and_finish;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {i_rst_b, i_axis_moving, i_motion_active, i_boot_load, i_dir_raw} = '0;
    {i_phys_dir_pin, i_net_fail_flag, i_launch_req} = '0;
    i_ce = 1'b1;
    i_bus = '0;
    i_boot_data = 24'h000000;
    i_gp_in = 3'h0;
    i_gp_out_req = 4'h0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    read_chk(AOR_OFS_CFG, 24'hc08500);
    check(o_cfg, 24'hc08500);
    read_chk(AOR_OFS_ASSIST, 24'h000000);
    read_chk(4'h9, 24'h000000);
    bus_op(AOR_OFS_CFG, 24'h000000, 1'b1);
    bus_op(AOR_OFS_ASSIST, 24'h123416, 1'b1);
    bus_op(AOR_OFS_CMD, 24'h000021, 1'b1);
    read_chk(AOR_OFS_CFG, 24'hc08500);
    @(posedge i_clk);
    i_ce <= 1'b0;
    bus_op(AOR_OFS_ASSIST, 24'habcd0f, 1'b1);
    i_ce <= 1'b1;
    read_chk(AOR_OFS_ASSIST, 24'h123416);
    i_axis_moving <= 1'b1;
    bus_op(AOR_OFS_CMD, {16'h0000, AOR_CMD_OPT_WRITE}, 1'b1);
    read_chk(AOR_OFS_CFG, 24'hc08500);
    read_chk(AOR_OFS_STAT, 24'((1 << AOR_STAT_REFUSED) | (1 << AOR_STAT_MOVING)));
    i_axis_moving <= 1'b0;
    set_cfg(24'hffff3f);
    read_chk(AOR_OFS_CFG, 24'hffff3f);
    read_chk(AOR_OFS_STAT, 24'(1 << AOR_STAT_TAKEN));
    // Each option without pin logic lands on its own bit
    for (int i = 0; i < 11; i++) begin
      set_cfg(24'(1 << bits[i]));
      check(o_cfg, 24'(1 << bits[i]));
      check({o_cfg.param_autofix_en, o_cfg.pattern_shrink_en, o_cfg.halt_notice_en,
             o_cfg.auto_launch_en, o_cfg.overscale_en, o_cfg.stop_style_sel,
             o_cfg.sync_source_sel, o_cfg.accel_format_sel, o_cfg.distance_mode_sel,
             o_cfg.limit_compare_src, o_cfg.limit_stop_en}, 24'(11'h400 >> i));
    end
    // Pin behaviour with all options off, then with inversions and gating
    @(posedge i_clk);
    {i_dir_raw, i_phys_dir_pin, i_net_fail_flag, i_launch_req, i_motion_active} <= 5'h1f;
    i_gp_out_req <= 4'ha;
    i_gp_in <= 3'h7;
    set_cfg(24'h000000);
    check({o_dir_pin, o_phys_dir}, 24'h3);
    check(o_gp_out, 24'ha);
    check(o_launch, 24'h1);
    check(o_net_stop, 24'h0);
    check({o_stop_signal, o_gp_in_plain}, 24'h7);
    @(posedge i_clk);
    i_gp_out_req <= 4'h2;
    set_cfg(24'h190c19);
    check({o_dir_pin, o_phys_dir}, 24'h0);
    check(o_gp_out, 24'hf);
    check(o_launch, 24'h0);
    check(o_net_stop, 24'h1);
    check({o_stop_signal, o_gp_in_plain}, 24'he);
    @(posedge i_clk);
    i_gp_out_req <= 4'ha;
    repeat (3) @(posedge i_clk);
    #1 check({o_launch, o_gp_out}, 24'h17);
    set_cfg(24'h000820);
    check(o_gp_out, 24'hc);
    for (int m = 0; m < 4; m++) begin
      set_cfg(24'(m << 1));
      check({o_stop_sensor, o_manual_step, o_manual_cont, o_gp_in_plain},
            24'({m == 1, m == 2, m == 3, (m == 0) ? 3'h7 : 3'h1}));
    end
    // Boot load of the saved value, then a second reset
    @(posedge i_clk);
    i_boot_data <= 24'h5a5aff;
    i_boot_load <= 1'b1;
    @(posedge i_clk);
    i_boot_load <= 1'b0;
    read_chk(AOR_OFS_CFG, 24'h5a5a3f);
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    read_chk(AOR_OFS_CFG, 24'hc08500);
    check(o_cfg, 24'hc08500);
    tally_and_finish();
  end
endmodule // aor_option_bank_tb
